// >>> hdpm_port_manager.sv
// Hub downstream port manager: connect/disconnect detection, speed and enable gating.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module hdpm_port_manager #(
  parameter int NUM_PORTS = hdpm_pkg::NUM_PORTS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic bus_reset,
  // Register port
  input wire hdpm_pkg::hdpm_req_type req,
  output logic [7:0] rdata,
  // Downstream line states
  input wire hdpm_pkg::hdpm_line_type [NUM_PORTS-1:0] line,
  // Repeater status and interrupt acknowledge
  input wire logic packet_active,
  input wire logic upstream_fs,
  input wire logic suspended,
  input wire logic eof2,
  input wire logic [NUM_PORTS-1:0] babble,
  input wire logic irq_ack,
  // Repeater gating and hub interrupt
  output logic [NUM_PORTS-1:0] pass_down,
  output logic [NUM_PORTS-1:0] pass_up,
  output logic hub_irq
);

  initial begin
    if (NUM_PORTS < 1 || NUM_PORTS > 4) begin
      $error("NUM_PORTS must lie between 1 and 4.");
    end
    // The counter saturates at all ones, so the connect count must stay below that.
    if (hdpm_pkg::CONNECT_CYCLES >= 2 ** hdpm_pkg::CNT_W - 1) begin
      $error("Connect count does not fit the qualification counter.");
    end
    if (hdpm_pkg::DISCONNECT_CYCLES >= hdpm_pkg::CONNECT_CYCLES) begin
      $error("Disconnect count must stay below the connect count.");
    end
  end

  logic clr;
  logic [NUM_PORTS-1:0] attach;
  logic [NUM_PORTS-1:0] speed;
  logic [NUM_PORTS-1:0] enable;
  logic [NUM_PORTS-1:0] enable_req;
  logic [NUM_PORTS-1:0] active;
  logic [NUM_PORTS-1:0] conn_evt;
  logic [NUM_PORTS-1:0] disc_evt;
  logic [NUM_PORTS-1:0] ls_seen;
  logic pending;
  logic irq_ena;
  hdpm_pkg::hdpm_line_type [NUM_PORTS-1:0] last_line;
  logic [hdpm_pkg::CNT_W-1:0] cnt [NUM_PORTS];

  // Counter values at which an event fires; the line history costs one cycle.
  localparam int CW = hdpm_pkg::CNT_W;
  localparam logic [CW-1:0] CONN_LAST = CW'(hdpm_pkg::CONNECT_CYCLES - 1);
  localparam logic [CW-1:0] DISC_LAST = CW'(hdpm_pkg::DISCONNECT_CYCLES - 1);

  function automatic logic is_se0(input hdpm_pkg::hdpm_line_type l);
    is_se0 = !l.dp && !l.dm;
  endfunction

  function automatic logic [7:0] pad_flags(input logic [NUM_PORTS-1:0] f);
    pad_flags = 8'h00;
    pad_flags[NUM_PORTS-1:0] = f;
  endfunction

  function automatic logic wr_at(input hdpm_pkg::hdpm_req_type r, input logic [7:0] a);
    wr_at = r.wr && r.addr == a;
  endfunction

  assign clr = !resetn || bus_reset;

  // Duration qualification per port.
  always_ff @(posedge clk) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (clr) begin
        cnt[p] <= '0;
        last_line[p] <= '0;
      end else begin
        last_line[p] <= line[p];
        if (line[p] != last_line[p]) begin
          cnt[p] <= '0;
        end else if (cnt[p] != '1) begin
          cnt[p] <= cnt[p] + 1'b1;
        end
      end
    end
  end

  // Qualified events; the sampled line history is one cycle behind, so counts are one short of elapsed time.
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      conn_evt[p] = !attach[p] && !is_se0(last_line[p]) && line[p] == last_line[p]
        && cnt[p] >= CONN_LAST;
      disc_evt[p] = attach[p] && is_se0(last_line[p]) && line[p] == last_line[p]
        && cnt[p] >= DISC_LAST;
      ls_seen[p] = !last_line[p].dp && last_line[p].dm;
    end
  end

  // Connect status; hardware events win over firmware writes.
  always_ff @(posedge clk) begin
    if (clr) begin
      attach <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (conn_evt[p]) begin
          attach[p] <= 1'b1;
        end else if (disc_evt[p]) begin
          attach[p] <= 1'b0;
        end else if (wr_at(req, hdpm_pkg::ADDR_ATTACH)) begin
          attach[p] <= req.wdata[p];
        end
      end
    end
  end

  // Speed: full-speed connects clear the bit; firmware sets low speed.
  always_ff @(posedge clk) begin
    if (clr) begin
      speed <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (conn_evt[p] && !ls_seen[p]) begin
          speed[p] <= 1'b0;
        end else if (wr_at(req, hdpm_pkg::ADDR_SPEED)) begin
          speed[p] <= req.wdata[p];
        end
      end
    end
  end

  // Enable: a written value waits for the current packet to end; babble at eof2 clears it.
  always_ff @(posedge clk) begin
    if (clr) begin
      enable_req <= '0;
      active <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (eof2 && babble[p]) begin
          enable_req[p] <= 1'b0;
          active[p] <= 1'b0;
        end else begin
          if (wr_at(req, hdpm_pkg::ADDR_ENABLE)) begin
            enable_req[p] <= req.wdata[p];
          end
          if (!packet_active) begin
            active[p] <= wr_at(req, hdpm_pkg::ADDR_ENABLE) ? req.wdata[p] : enable_req[p];
          end
        end
      end
    end
  end

  assign enable = enable_req;

  // Repeater gating.
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      pass_down[p] = active[p] && !suspended && !(upstream_fs && speed[p]);
      pass_up[p] = active[p] && !suspended && !babble[p];
    end
  end

  // Hub interrupt: pending until acknowledged; a new event wins over the acknowledge.
  always_ff @(posedge clk) begin
    if (clr) begin
      pending <= 1'b0;
      irq_ena <= 1'b1;
    end else begin
      if (wr_at(req, hdpm_pkg::ADDR_IRQ)) begin
        irq_ena <= req.wdata[hdpm_pkg::IRQ_ENA_BIT];
      end
      if (|(conn_evt | disc_evt)) begin
        pending <= 1'b1;
      end else if (irq_ack) begin
        pending <= 1'b0;
      end
    end
  end

  assign hub_irq = pending && irq_ena;

  // Read data, one cycle after the strobe; upper bits read zero.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata <= hdpm_pkg::RESET_FLAGS;
    end else if (req.rd) begin
      case (req.addr)
        hdpm_pkg::ADDR_ATTACH: rdata <= pad_flags(attach);
        hdpm_pkg::ADDR_ENABLE: rdata <= pad_flags(enable);
        hdpm_pkg::ADDR_SPEED: rdata <= pad_flags(speed);
        hdpm_pkg::ADDR_IRQ: rdata <= {6'h00, irq_ena, pending};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  a_connect_qualify: assert property (@(posedge clk) disable iff (clr)
    $rose(attach[0]) && !$past(wr_at(req, hdpm_pkg::ADDR_ATTACH))
      |-> $past(!is_se0(line[0]), 1) && $past(!is_se0(line[0]), 250))
    else $error("Connect recorded before qualification time.");

  a_disconnect_irq: assert property (@(posedge clk) disable iff (clr)
    disc_evt[0] |=> !attach[0] && pending)
    else $error("Disconnect did not clear status and raise interrupt.");

  a_fs_speed_clear: assert property (@(posedge clk) disable iff (clr)
    conn_evt[1] && !ls_seen[1] |=> attach[1] && !speed[1])
    else $error("Full-speed connect left speed bit set.");

  a_upper_zero: assert property (@(posedge clk) disable iff (clr)
    $past(req.rd) |-> rdata[7:4] == 4'h0)
    else $error("Reserved bits read nonzero.");

  a_gate_enable: assert property (@(posedge clk) disable iff (clr)
    !active[2] |-> !pass_down[2] && !pass_up[2])
    else $error("Traffic passed on a disabled port.");

  a_no_fs_to_ls: assert property (@(posedge clk) disable iff (clr)
    upstream_fs && speed[0] |-> !pass_down[0])
    else $error("Full-speed traffic sent to a low-speed port.");

  a_enable_wait: assert property (@(posedge clk) disable iff (clr)
    packet_active && !(eof2 && babble[0]) |=> active[0] == $past(active[0]))
    else $error("Enable changed during a packet.");

  a_babble_clear: assert property (@(posedge clk) disable iff (clr)
    eof2 && babble[3] |=> !enable[3] && !active[3])
    else $error("Babble did not disable the port.");

  a_irq_hold: assert property (@(posedge clk) disable iff (clr)
    pending && !irq_ack |=> pending)
    else $error("Interrupt dropped without acknowledge.");

  a_bus_reset: assert property (@(posedge clk)
    bus_reset |=> attach == '0 && speed == '0 && enable == '0)
    else $error("Bus reset did not clear port registers.");

  a_chip_reset: assert property (@(posedge clk)
    !resetn |=> attach == '0 && speed == '0 && !pending)
    else $error("Chip reset did not clear port state.");

  a_enable_reset: assert property (@(posedge clk)
    !resetn |=> enable == '0 && active == '0)
    else $error("Reset left a port enabled.");

  a_rdata_reset: assert property (@(posedge clk)
    !resetn |=> rdata == 8'h00)
    else $error("Read data not cleared by reset.");

  a_connect_irq: assert property (@(posedge clk) disable iff (clr)
    conn_evt[0] |=> attach[0] && pending)
    else $error("Connect did not set status and interrupt.");

  a_ls_connect: assert property (@(posedge clk) disable iff (clr)
    conn_evt[1] && ls_seen[1] |=> attach[1] && pending)
    else $error("Low-speed connect did not set status and interrupt.");

  a_disconnect_se0: assert property (@(posedge clk) disable iff (clr)
    $fell(attach[0]) && !$past(clr) && !$past(wr_at(req, hdpm_pkg::ADDR_ATTACH))
      |-> $past(is_se0(line[0]), 1) && $past(is_se0(line[0]), 200))
    else $error("Disconnect recorded before the SE0 time.");

  a_port3_disconnect: assert property (@(posedge clk) disable iff (clr)
    disc_evt[3] |=> !attach[3] && pending)
    else $error("Disconnect on the last port was lost.");

  a_count_restart: assert property (@(posedge clk) disable iff (clr)
    line[0] != last_line[0] |=> cnt[0] == '0)
    else $error("Qualification counter did not restart.");

  a_ack_clear: assert property (@(posedge clk) disable iff (clr)
    pending && irq_ack && !(|(conn_evt | disc_evt)) |=> !pending)
    else $error("Acknowledge did not clear the interrupt.");

  a_suspend_event: assert property (@(posedge clk) disable iff (clr)
    suspended && |(conn_evt | disc_evt) |=> pending)
    else $error("Event in suspend raised no interrupt.");

  a_suspend_gate: assert property (@(posedge clk) disable iff (clr)
    suspended |-> pass_down == '0 && pass_up == '0)
    else $error("Traffic passed while suspended.");

  a_babble_block: assert property (@(posedge clk) disable iff (clr)
    babble[1] |-> !pass_up[1])
    else $error("Babbling port forwarded upstream.");

  a_up_forward: assert property (@(posedge clk) disable iff (clr)
    active[0] && !suspended && !babble[0] |-> pass_up[0])
    else $error("Enabled port did not forward upstream.");

  a_down_forward: assert property (@(posedge clk) disable iff (clr)
    active[3] && !suspended && !(upstream_fs && speed[3]) |-> pass_down[3])
    else $error("Enabled port did not receive upstream traffic.");

  a_enable_idle: assert property (@(posedge clk) disable iff (clr)
    !packet_active && !eof2 && wr_at(req, hdpm_pkg::ADDR_ENABLE) |=> active == $past(req.wdata[NUM_PORTS-1:0]))
    else $error("Enable on an idle bus did not apply at once.");

  a_rdata_idle: assert property (@(posedge clk) disable iff (clr)
    !req.rd |=> rdata == 8'h00)
    else $error("Read data stood without a read strobe.");

endmodule

`default_nettype wire

// >>> hdpm_pkg.sv
// Package for the hub downstream port manager: offsets, layouts, timing counts.
package hdpm_pkg;
  localparam int NUM_PORTS = 4;
  localparam logic [7:0] ADDR_ATTACH = 8'h48;
  localparam logic [7:0] ADDR_ENABLE = 8'h49;
  localparam logic [7:0] ADDR_SPEED = 8'h4a;
  localparam logic [7:0] ADDR_IRQ = 8'h4c;
  localparam logic [7:0] RESET_FLAGS = 8'h00;
  localparam int IRQ_PEND_BIT = 0;
  localparam int IRQ_ENA_BIT = 1;
  localparam int CLK_MHZ = 100;
  localparam int CONNECT_NS = 2500;
  localparam int DISCONNECT_NS = 2000;
  localparam int CONNECT_CYCLES = (CONNECT_NS * CLK_MHZ + 999) / 1000 + 1;
  localparam int DISCONNECT_CYCLES = (DISCONNECT_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 9;

  typedef struct packed {
    logic dp;
    logic dm;
  } hdpm_line_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } hdpm_req_type;
endpackage

// >>> hdpm_dev_model.sv
// Model of the four downstream devices that sit on the hub ports.
`timescale 1ns/1ps
`default_nettype none
module hdpm_dev_model (
  // Per-port attach mode: 0 none, 1 full speed, 2 low speed
  input wire logic [7:0] mode,
  // Line levels seen by the hub
  output hdpm_pkg::hdpm_line_type [3:0] line
);
  // A detached port reads SE0 because the hub's pull-downs win.
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      case (mode[2*p+:2])
        2'h1: line[p] = '{dp: 1'b1, dm: 1'b0};
        2'h2: line[p] = '{dp: 1'b0, dm: 1'b1};
        default: line[p] = '{dp: 1'b0, dm: 1'b0};
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> hdpm_port_manager_bench.sv
// Self-checking bench for the hub downstream port manager.
`timescale 1ns/1ps
`default_nettype none
module hdpm_port_manager_bench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic bus_reset = 1'b0;
  hdpm_pkg::hdpm_req_type req = '0;
  logic [7:0] rdata;
  hdpm_pkg::hdpm_line_type [3:0] line;
  logic [7:0] mode = 8'h00;
  logic packet_active = 1'b0;
  logic upstream_fs = 1'b0;
  logic suspended = 1'b0;
  logic eof2 = 1'b0;
  logic [3:0] babble = 4'h0;
  logic irq_ack = 1'b0;
  logic [3:0] pass_down;
  logic [3:0] pass_up;
  logic hub_irq;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h80cd;
  logic [3:0] hub_change = 4'h0;
  logic [7:0] seen;

  hdpm_port_manager i_dut (.clk(clk), .resetn(resetn), .bus_reset(bus_reset), .req(req), .rdata(rdata),
    .line(line), .packet_active(packet_active), .upstream_fs(upstream_fs), .suspended(suspended),
    .eof2(eof2), .babble(babble), .irq_ack(irq_ack), .pass_down(pass_down), .pass_up(pass_up),
    .hub_irq(hub_irq));
  hdpm_dev_model i_dev (.mode(mode), .line(line));

  initial begin
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic report_and_stop;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask

  // Read data stand only in the cycle after the read strobe is taken.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1;
    d = rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      report_and_stop;
    end
  end

  initial begin
    cyc(12);
    resetn <= 1'b1;
    rdchk(hdpm_pkg::ADDR_ATTACH, 8'h00);
    rdchk(hdpm_pkg::ADDR_ENABLE, 8'h00);
    rdchk(hdpm_pkg::ADDR_SPEED, 8'h00);
    rdchk(hdpm_pkg::ADDR_IRQ, 8'h02);
    rdchk(8'h4b, 8'h00);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(hdpm_pkg::ADDR_SPEED, seed[7:0]);
      rdchk(hdpm_pkg::ADDR_SPEED, seed[7:0] & 8'h0f);
    end
    wr(hdpm_pkg::ADDR_SPEED, 8'h03);
    mode <= 8'h09;
    cyc(240);
    rdchk(hdpm_pkg::ADDR_ATTACH, 8'h00);
    chk(hub_irq, 1'b0);
    cyc(20);
    rdchk(hdpm_pkg::ADDR_ATTACH, 8'h03);
    rdchk(hdpm_pkg::ADDR_SPEED, 8'h02);
    chk(hub_irq, 1'b1);
    rd(hdpm_pkg::ADDR_ATTACH, seen);
    hub_change = seen[3:0];
    chk(hub_change, 4'h3);
    @(posedge clk) irq_ack <= 1'b1;
    @(posedge clk) irq_ack <= 1'b0;
    cyc(1);
    chk(hub_irq, 1'b0);
    wr(hdpm_pkg::ADDR_ATTACH, 8'hf3);
    rdchk(hdpm_pkg::ADDR_ATTACH, 8'h03);
    // Enable lands while a packet is in flight, so it must wait.
    packet_active <= 1'b1;
    upstream_fs <= 1'b1;
    wr(hdpm_pkg::ADDR_ENABLE, 8'h03);
    cyc(3);
    chk(pass_down, 4'h0);
    packet_active <= 1'b0;
    cyc(2);
    chk(pass_down, 4'h1);
    chk(pass_up, 4'h3);
    babble <= 4'h2;
    cyc(1);
    chk(pass_up, 4'h1);
    @(posedge clk) eof2 <= 1'b1;
    @(posedge clk) eof2 <= 1'b0;
    babble <= 4'h0;
    upstream_fs <= 1'b0;
    cyc(2);
    chk(pass_up, 4'h1);
    chk(pass_down, 4'h1);
    suspended <= 1'b1;
    mode <= 8'h08;
    cyc(190);
    chk(hub_irq, 1'b0);
    cyc(55);
    chk(hub_irq, 1'b1);
    rdchk(hdpm_pkg::ADDR_ATTACH, 8'h02);
    rd(hdpm_pkg::ADDR_ATTACH, seen);
    hub_change = hub_change ^ seen[3:0];
    chk(hub_change, 4'h1);
    wr(hdpm_pkg::ADDR_IRQ, 8'h00);
    rdchk(hdpm_pkg::ADDR_IRQ, 8'h01);
    chk(hub_irq, 1'b0);
    wr(hdpm_pkg::ADDR_IRQ, 8'h02);
    rdchk(hdpm_pkg::ADDR_IRQ, 8'h03);
    chk(hub_irq, 1'b1);
    @(posedge clk) bus_reset <= 1'b1;
    @(posedge clk) bus_reset <= 1'b0;
    rdchk(hdpm_pkg::ADDR_ATTACH, 8'h00);
    rdchk(hdpm_pkg::ADDR_ENABLE, 8'h00);
    rdchk(hdpm_pkg::ADDR_SPEED, 8'h00);
    report_and_stop;
  end
endmodule
`default_nettype wire
